// File: inc/ips_pkg.sv
// package: register map, field layout and source constants of the priority block
package ips_pkg;
	localparam int          NSRC      = 5;  // user sources
	localparam int          NTRAP     = 4;  // trap sources
	localparam int          AW        = 5;  // byte address width
	// byte offsets
	localparam logic [4:0]  OFS_CAPX1 = 5'h00;
	localparam logic [4:0]  OFS_EXT2  = 5'h04;
	localparam logic [4:0]  OFS_SERR  = 5'h08;
	localparam logic [4:0]  OFS_STAT  = 5'h0c;
	localparam logic [4:0]  OFS_CPU   = 5'h10;
	// source indices
	localparam int          SRC_CAP7  = 0;
	localparam int          SRC_CAP8  = 1;
	localparam int          SRC_EXT1  = 2;
	localparam int          SRC_EXT2  = 3;
	localparam int          SRC_SERR  = 4;
	// field positions
	localparam int          POS_CAP7  = 8;
	localparam int          POS_CAP8  = 12;
	localparam int          POS_EXT1  = 0;
	localparam int          POS_EXT2  = 4;
	localparam int          POS_SERR  = 4;
	localparam int          POS_LVL   = 8;
	localparam int          POS_VEC   = 0;
	// reset values
	localparam logic [2:0]  PRIO_RST  = 3'h4;
	localparam logic [2:0]  CPU_RST   = 3'h0;
	// vector codes (code n is vector n+8)
	localparam logic [NSRC-1:0][6:0] SRC_VEC =
		{7'h2d, 7'h20, 7'h1c, 7'h15, 7'h0e};
	localparam logic [NTRAP-1:0][6:0] TRAP_VEC =
		{7'h04, 7'h03, 7'h02, 7'h01};
	localparam logic [3:0]  TRAP_BASE = 4'h8; // trap i sits at level 8+i

	// three-bit priority code to level: 000 off, 001..111 level 1..7
	function automatic logic [3:0] ips_level(input logic [2:0] code);
		ips_level = {1'b0, code};
	endfunction : ips_level
endpackage : ips_pkg

// File: logic/ips_pick.sv
// module: picks the highest requesting source above the cpu level
`timescale 1ns/100ps
module ips_pick
	import ips_pkg::*;
(
	input  wire logic [ips_pkg::NSRC-1:0][2:0] prio,     // user priority codes
	input  wire logic [ips_pkg::NSRC-1:0]      srcReq,   // flagged and enabled
	input  wire logic [ips_pkg::NTRAP-1:0]     trapReq,  // trap requests
	input  wire logic [2:0]                    cpuLevel, // current cpu level
	output logic                               found,    // something pending
	output logic [3:0]                         level,    // winner level
	output logic [6:0]                         vecCode   // winner vector code
);
	// scan in index order; a strict compare keeps the lower index on a tie
	always_comb
	begin
		found   = 1'b0;
		level   = {1'b0, cpuLevel};
		vecCode = 7'h00;
		for (int i = 0; i < NSRC; i++)
		begin
			// code 000 gives level 0, never above the cpu level
			if (srcReq[i] && ips_level(prio[i]) > level)
			begin
				found   = 1'b1;
				level   = ips_level(prio[i]);
				vecCode = SRC_VEC[i];
			end
		end
		// traps sit at 8..11, always above any user cpu level
		for (int t = 0; t < NTRAP; t++)
		begin
			if (trapReq[t])
			begin
				found   = 1'b1;
				level   = TRAP_BASE + 4'(t);
				vecCode = TRAP_VEC[t];
			end
		end
	end
endmodule : ips_pick

// File: logic/ips_top.sv
// module: priority fields, pending status and avalon-mm register slave
//
// Summary of operation
// - priority code 111 puts a source at level 7, the highest user level
// - code 001 is level 1, 000 disables the source, others are linear
// - unimplemented bits of priority and status registers read zero
// - first register: capture 7 at 10:8, capture 8 at 14:12, ext1 at 2:0
// - status bits 11:8 report the new cpu level, 0 to 11
// - status bits 6:0 report the pending vector code, n means n+8
// - after reset every user priority field holds level 4
// - trap levels 8 to 11 are never masked by the cpu level
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
module ips_top
	import ips_pkg::*;
(
	input  wire logic                       clk,           // 40 MHz clock
	input  wire logic                       arst_n,        // async reset
	input  wire logic [ips_pkg::AW-1:0]     address,       // byte address
	input  wire logic                       read,          // read request
	input  wire logic                       write,         // write request
	input  wire logic [3:0]                 byteenable,    // lane enables
	input  wire logic [31:0]                writedata,     // write data
	output logic [31:0]                     readdata,      // read data
	output logic                            waitrequest,   // stall
	input  wire logic [ips_pkg::NSRC-1:0]   srcReq,        // source requests
	input  wire logic [ips_pkg::NTRAP-1:0]  trapReq,       // trap requests
	output logic                            irqPending,    // request to core
	output logic [3:0]                      newCpuLevel,   // pending level
	output logic [6:0]                      pendVector     // pending vector
);
	typedef struct packed {
		logic [NSRC-1:0][2:0] prio;
		logic [2:0]           cpuLevel;
		logic                 wait_;
		logic [31:0]          rdata;
		logic                 pend;
		logic [3:0]           level;
		logic [6:0]           vec;
	} ips_state_s;

	ips_state_s stateQ;
	ips_state_s stateD;
	logic       pickFound;
	logic [3:0] pickLevel;
	logic [6:0] pickVec;
	logic       reqOn;
	logic       accept;

	////////////////////////////////////////////////////////////////////////
	// arbitration
	ips_pick uPick (
		.prio     (stateQ.prio),
		.srcReq   (srcReq),
		.trapReq  (trapReq),
		.cpuLevel (stateQ.cpuLevel),
		.found    (pickFound),
		.level    (pickLevel),
		.vecCode  (pickVec)
	);

	////////////////////////////////////////////////////////////////////////
	// register read image; only documented fields reach the bus
	function automatic logic [31:0] regRead(input ips_state_s s,
		input logic [AW-1:0] a);
		regRead = 32'h0000_0000; // unmapped and unused bits read zero
		unique case (a)
			OFS_CAPX1:
			begin
				regRead[POS_CAP7 +: 3] = s.prio[SRC_CAP7];
				regRead[POS_CAP8 +: 3] = s.prio[SRC_CAP8];
				regRead[POS_EXT1 +: 3] = s.prio[SRC_EXT1];
			end
			OFS_EXT2: regRead[POS_EXT2 +: 3] = s.prio[SRC_EXT2];
			OFS_SERR: regRead[POS_SERR +: 3] = s.prio[SRC_SERR];
			OFS_STAT:
			begin
				regRead[POS_LVL +: 4] = s.level;
				regRead[POS_VEC +: 7] = s.vec;
			end
			OFS_CPU:  regRead[2:0] = s.cpuLevel;
			default:  regRead = 32'h0000_0000;
		endcase
	endfunction : regRead

	////////////////////////////////////////////////////////////////////////
	// next state: one wait cycle per access, write lands on the release edge
	assign reqOn  = read || write;
	assign accept = reqOn && !stateQ.wait_;

	always_comb
	begin
		stateD = stateQ;
		// status follows the winner every cycle
		stateD.pend  = pickFound;
		stateD.level = pickLevel;
		stateD.vec   = pickVec;
		// bus handshake: waitrequest drops for exactly one cycle
		if (accept)
			stateD.wait_ = 1'b1;
		else if (reqOn)
			stateD.wait_ = 1'b0;
		if (reqOn && stateQ.wait_)
			stateD.rdata = regRead(stateQ, address);
		// writes touch only field bits, so reserved bits stay zero
		if (accept && write)
		begin
			unique case (address)
				OFS_CAPX1:
				begin
					if (byteenable[1])
					begin
						stateD.prio[SRC_CAP7] = writedata[POS_CAP7 +: 3];
						stateD.prio[SRC_CAP8] = writedata[POS_CAP8 +: 3];
					end
					if (byteenable[0])
						stateD.prio[SRC_EXT1] = writedata[POS_EXT1 +: 3];
				end
				OFS_EXT2:
					if (byteenable[0])
						stateD.prio[SRC_EXT2] = writedata[POS_EXT2 +: 3];
				OFS_SERR:
					if (byteenable[0])
						stateD.prio[SRC_SERR] = writedata[POS_SERR +: 3];
				// cpu level is 3 bits, so it can never reach trap levels
				OFS_CPU:
					if (byteenable[0])
						stateD.cpuLevel = writedata[2:0];
				default: ; // status is read only, unmapped ignored
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stateQ          <= '0;
			stateQ.prio     <= {NSRC{PRIO_RST}}; // every source at level 4
			stateQ.cpuLevel <= CPU_RST;
			stateQ.wait_    <= 1'b1;
		end
		else
			stateQ <= stateD;
	end

	// outputs straight from the state flops
	assign readdata    = stateQ.rdata;
	assign waitrequest = stateQ.wait_;
	assign irqPending  = stateQ.pend;
	assign newCpuLevel = stateQ.level;
	assign pendVector  = stateQ.vec;

	////////////////////////////////////////////////////////////////////////
	// checks
	logic initSeenQ;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			initSeenQ <= 1'b0;
		else
			initSeenQ <= 1'b1;
	end

	a_prio_reset_four: assert property (
		@(posedge clk) disable iff (!arst_n)
		!initSeenQ |-> stateQ.prio == {NSRC{PRIO_RST}})
		else $error("priority fields not at level 4 after reset");

	a_cap_field_write: assert property (
		@(posedge clk) disable iff (!arst_n)
		(write && !waitrequest && address == OFS_CAPX1 && byteenable[1])
		|=> stateQ.prio[SRC_CAP7] == $past(writedata[10:8])
		&& stateQ.prio[SRC_CAP8] == $past(writedata[14:12]))
		else $error("capture priority field write misplaced");

	a_unused_read_zero: assert property (
		@(posedge clk) disable iff (!arst_n)
		(read && !waitrequest && address == OFS_CAPX1)
		|-> (readdata & 32'hffff_8888) == 32'h0000_0000)
		else $error("unimplemented bits read nonzero");

	a_status_level_vec: assert property (
		@(posedge clk) disable iff (!arst_n)
		(read && !waitrequest && address == OFS_STAT)
		|-> readdata[11:8] == $past(newCpuLevel)
		&& readdata[6:0] == $past(pendVector) && readdata[7] == 1'b0)
		else $error("status fields do not match pending state");

	a_vector_of_pending: assert property (
		@(posedge clk) disable iff (!arst_n)
		##1 (irqPending && newCpuLevel < TRAP_BASE)
		|-> pendVector inside {SRC_VEC[0], SRC_VEC[1], SRC_VEC[2],
			SRC_VEC[3], SRC_VEC[4]})
		else $error("user level pending without a user vector");

	a_disabled_silent: assert property (
		@(posedge clk) disable iff (!arst_n)
		(srcReq == 5'h01 && trapReq == 4'h0 && stateQ.prio[0] == 3'h0)
		|=> !irqPending)
		else $error("disabled source was granted");

	a_level_seven_top: assert property (
		@(posedge clk) disable iff (!arst_n)
		(srcReq[SRC_SERR] && stateQ.prio[SRC_SERR] == 3'h7
		&& trapReq == 4'h0 && stateQ.cpuLevel != 3'h7)
		|=> irqPending && newCpuLevel == 4'h7)
		else $error("priority 111 source not at level 7");

	a_trap_unmasked: assert property (
		@(posedge clk) disable iff (!arst_n)
		(|trapReq) |=> irqPending && newCpuLevel >= TRAP_BASE)
		else $error("trap masked by cpu level");

	a_above_cpu_level: assert property (
		@(posedge clk) disable iff (!arst_n)
		##1 irqPending |-> newCpuLevel > {1'b0, $past(stateQ.cpuLevel)})
		else $error("pending level not above cpu level");

	c_prio_write: cover property (@(posedge clk) disable iff (!arst_n)
		write && !waitrequest && address == OFS_EXT2);
	c_status_read: cover property (@(posedge clk) disable iff (!arst_n)
		read && !waitrequest && address == OFS_STAT && irqPending);
	c_trap_over_user: cover property (@(posedge clk) disable iff (!arst_n)
		(|trapReq) && (|srcReq));
	c_user_disabled: cover property (@(posedge clk) disable iff (!arst_n)
		srcReq[SRC_CAP7] && stateQ.prio[SRC_CAP7] == 3'h0);
endmodule : ips_top

// File: bench/ips_src_model.sv
// source side model: flag and enable logic feeding the request lines
`timescale 1ns/100ps
module ips_src_model
	import ips_pkg::*;
(
	input  wire logic                      clk,     // system clock
	input  wire logic                      arst_n,  // async reset
	input  wire logic [ips_pkg::NSRC-1:0]  setSrc,  // wanted user lines
	input  wire logic [ips_pkg::NTRAP-1:0] setTrap, // wanted trap lines
	output logic [ips_pkg::NSRC-1:0]       srcReq,  // to the block
	output logic [ips_pkg::NTRAP-1:0]      trapReq  // to the block
);
	// lines follow one edge late, as a real flag register would
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			srcReq  <= '0;
			trapReq <= '0;
		end
		else
		begin
			srcReq  <= setSrc;
			trapReq <= setTrap;
		end
	end
endmodule : ips_src_model

// File: bench/tb_top.sv
// testbench: register map, reset values and winner selection
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %0t got %h want %h", $time, g, e); end end
module tb_top;
	import ips_pkg::*;
	logic              clk = 0;
	logic              arst_n = 0;
	logic              read = 0;
	logic              write = 0;
	logic [4:0]        address = '0;
	logic [3:0]        byteenable = '0;
	logic [31:0]       writedata = '0;
	logic [31:0]       readdata;
	logic [31:0]       q;
	logic              waitrequest;
	logic              irqPending;
	logic [3:0]        newCpuLevel;
	logic [6:0]        pendVector;
	logic [NSRC-1:0]   setSrc = '0;
	logic [NSRC-1:0]   srcReq;
	logic [NTRAP-1:0]  setTrap = '0;
	logic [NTRAP-1:0]  trapReq;
	logic [4:0]        ofs [5] = '{OFS_CAPX1, OFS_EXT2, OFS_SERR,
		OFS_STAT, OFS_CPU};
	logic [31:0]       rv [5] = '{32'h0000_4404, 32'h0000_0040,
		32'h0000_0040, 32'h0000_0000, 32'h0000_0000};
	int                n_fail = 0;
	int                cmp_count = 0;
	int                cyc = 0;
	ips_top i_dut (.clk(clk), .arst_n(arst_n), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .srcReq(srcReq), .trapReq(trapReq),
		.irqPending(irqPending), .newCpuLevel(newCpuLevel),
		.pendVector(pendVector));
	ips_src_model i_src (.clk(clk), .arst_n(arst_n), .setSrc(setSrc),
		.setTrap(setTrap), .srcReq(srcReq), .trapReq(trapReq));
	////////////////////////////////////////////////////////////////////
	// clock and a ceiling well above the fewer than 200 cycles needed
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////
	// one avalon access: the request stands until waitrequest is seen low
	// at a rising edge; read data is taken at that same edge, then released
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		address    <= a;
		byteenable <= be;
		writedata  <= d;
		write      <= w;
		read       <= !w;
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask : bus
	// model adds one edge, the block one more; sample mid-cycle
	task settle;
		repeat (3) @(negedge clk);
	endtask : settle
	////////////////////////////////////////////////////////////////////
	// reset values, lane enables, read-only and unmapped places
	task t_regs;
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, ofs[i], 4'hf, 32'h0000_0000);
			`CHK(q, rv[i])
		end
		bus(1'b1, OFS_CAPX1, 4'hf, 32'hffff_ffff);
		bus(1'b0, OFS_CAPX1, 4'hf, 32'h0000_0000);
		`CHK(q, 32'h0000_7707)
		bus(1'b1, OFS_CAPX1, 4'h1, 32'h0000_0000);
		bus(1'b0, OFS_CAPX1, 4'hf, 32'h0000_0000);
		`CHK(q, 32'h0000_7700)
		bus(1'b1, OFS_STAT, 4'hf, 32'hffff_ffff);
		bus(1'b0, OFS_STAT, 4'hf, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		bus(1'b1, 5'h14, 4'hf, 32'hffff_ffff);
		bus(1'b0, 5'h14, 4'hf, 32'h0000_0000);
		`CHK(q, 32'h0000_0000)
		bus(1'b1, OFS_CAPX1, 4'hf, 32'h0000_4404);
	endtask : t_regs
	// winner choice, disable, cpu masking and traps above it
	task t_pick;
		setSrc <= 5'h1f;
		settle();
		`CHK(pendVector, 7'h0e)
		`CHK(newCpuLevel, 4'h4)
		bus(1'b1, OFS_SERR, 4'hf, 32'h0000_0070);
		settle();
		`CHK(newCpuLevel, 4'h7)
		`CHK(pendVector, 7'h2d)
		bus(1'b1, OFS_SERR, 4'hf, 32'h0000_0000);
		setSrc <= 5'h10;
		settle();
		`CHK(irqPending, 1'b0)
		`CHK(pendVector, 7'h00)
		bus(1'b1, OFS_CAPX1, 4'hf, 32'h0000_4004);
		setSrc <= 5'h01;
		settle();
		`CHK(irqPending, 1'b0)
		`CHK(newCpuLevel, 4'h0)
		bus(1'b1, OFS_EXT2, 4'hf, 32'h0000_0010);
		setSrc <= 5'h18;
		settle();
		`CHK(newCpuLevel, 4'h1)
		`CHK(pendVector, 7'h20)
		bus(1'b1, OFS_CPU, 4'hf, 32'h0000_0007);
		settle();
		`CHK(irqPending, 1'b0)
		`CHK(newCpuLevel, 4'h7)
		@(posedge clk);
		setTrap <= 4'h9;
		settle();
		`CHK(newCpuLevel, 4'hb)
		bus(1'b0, OFS_STAT, 4'hf, 32'h0000_0000);
		`CHK(q, 32'h0000_0b04)
	endtask : t_pick
	// mid-run reset: fields changed above must come back at level 4
	task t_reset;
		@(posedge clk);
		arst_n <= 1'b0;
		@(negedge clk);
		`CHK(irqPending, 1'b0)
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			bus(1'b0, ofs[i], 4'hf, 32'h0000_0000);
			`CHK(q, rv[i])
		end
		settle();
		`CHK(newCpuLevel, 4'hb)
		`CHK(pendVector, 7'h04)
	endtask : t_reset
	////////////////////////////////////////////////////////////////////
	// verdict in one place
	task results;
		$display("fails %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	initial
	begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_pick();
		t_reset();
		results();
	end
endmodule : tb_top
